// >>> design/dtp_timer_pair.sv
`timescale 1ns/1ps
`default_nettype none
module dtp_timer_pair
    import dtp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic i_shared_count_pin,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_irq
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    // kept outside the state struct: it produces the reset that
    // the struct itself is cleared by
    logic [1:0] rst_sync_r;
    logic rst_n;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_r[1];

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic is_mapped(input logic [5:0] idx);
        logic hit;
        hit = 1'b0;
        unique case (idx)
            IDX_COUNT_A, IDX_COUNT_B, IDX_PERIOD_A, IDX_PERIOD_B,
            IDX_PAIR_CTRL, IDX_RUN_CTRL, IDX_REQUEST, IDX_ENABLE,
            IDX_INT_STATUS, IDX_CPU_STATUS: begin
                hit = 1'b1;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction

    function automatic logic [7:0] read_value(
        input dtp_state_t s,
        input logic [5:0] idx
    );
        logic [7:0] v;
        v = RST_BYTE;
        unique case (idx)
            IDX_COUNT_A: begin
                v = s.count_a;
            end
            IDX_COUNT_B: begin
                v = s.count_b;
            end
            IDX_PERIOD_A: begin
                v = s.period_a;
            end
            IDX_PERIOD_B: begin
                v = s.period_b;
            end
            IDX_PAIR_CTRL: begin
                v = s.pair_ctrl;
            end
            IDX_RUN_CTRL: begin
                v = s.run_ctrl;
            end
            IDX_REQUEST: begin
                v = s.request;
            end
            IDX_ENABLE: begin
                v = s.enable;
            end
            IDX_INT_STATUS: begin
                v = s.int_status;
            end
            IDX_CPU_STATUS: begin
                v = s.cpu_status;
            end
            default: begin
                v = RST_BYTE;
            end
        endcase
        return v;
    endfunction

    // match that ends an 8-bit period
    function automatic logic at_period8(
        input logic [7:0] count,
        input logic [7:0] period
    );
        logic v;
        v = (count == period);
        return v;
    endfunction

    // step an 8-bit counter: zero after a period match
    function automatic logic [7:0] step8(
        input logic [7:0] count,
        input logic [7:0] period
    );
        logic [7:0] v;
        v = at_period8(count, period) ? RST_BYTE : 8'(count + 8'h01);
        return v;
    endfunction

    // step the chained pair: zero after a full 16-bit match
    function automatic logic [15:0] step16(
        input logic [15:0] count,
        input logic [15:0] period
    );
        logic [15:0] v;
        v = (count == period) ? 16'h0000 : 16'(count + 16'h0001);
        return v;
    endfunction

    // count source: pin falls in counter mode, else the tick
    function automatic logic count_event(
        input logic use_pin,
        input logic fall,
        input logic tick
    );
        logic v;
        v = use_pin ? fall : tick;
        return v;
    endfunction

    // interrupt line: an enabled flag, then the two gates
    function automatic logic irq_level(input dtp_state_t s);
        logic [7:0] pending;
        logic v;
        pending = s.request & s.enable & REQUEST_MASK;
        v = (|pending) & s.int_status[PERIPH_EN_BIT] &
            ~s.cpu_status[GLOBAL_DIS_BIT];
        return v;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    dtp_state_t st_r;
    dtp_state_t st_nxt;

    logic pin_fall;
    logic sample_en;

    assign sample_en = (st_r.phase == SAMPLE_PHASE_0) |
                       (st_r.phase == SAMPLE_PHASE_1);

    // a pin fall reaches the counter two to three clocks later
    dtp_pin_sampler u_pin_sampler (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_sample_en(sample_en),
        .i_pin(i_shared_count_pin),
        .o_fall(pin_fall)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic [5:0] idx;
    logic acc_first;
    logic acc_done;
    logic wr;
    logic instr_tick;
    logic wide;
    logic ev_a;
    logic ev_b;
    logic inc_a;
    logic inc_b;
    logic set_a;
    logic set_b;
    logic [15:0] count16;
    logic [15:0] period16;
    logic [15:0] next16;
    logic [7:0] wdat;

    always_comb begin
        st_nxt = st_r;
        idx = i_paddr[7:2];
        wdat = i_pwdata[7:0];

        // --------------------------------------------------------
        // bus answer: one wait state, then a registered reply
        // --------------------------------------------------------
        acc_first = i_psel & i_penable & ~st_r.pready;
        acc_done = i_psel & i_penable & st_r.pready;
        wr = acc_done & i_pwrite & is_mapped(idx);
        st_nxt.pready = acc_first;
        st_nxt.pslverr = acc_first & ~is_mapped(idx);
        st_nxt.prdata = RST_WORD;
        if (acc_first & ~i_pwrite) begin
            st_nxt.prdata = {24'h00_0000, read_value(st_r, idx)};
        end

        // --------------------------------------------------------
        // instruction phase counter
        // --------------------------------------------------------
        st_nxt.phase = 2'(st_r.phase + 2'h1);
        instr_tick = (st_r.phase == TICK_PHASE);

        // --------------------------------------------------------
        // count sources
        // --------------------------------------------------------
        wide = st_r.pair_ctrl[WIDE_BIT];
        ev_a = count_event(st_r.pair_ctrl[SRC_A_BIT], pin_fall,
                           instr_tick);
        ev_b = count_event(st_r.pair_ctrl[SRC_B_BIT], pin_fall,
                           instr_tick);
        // run B is assumed held high in wide mode and is not looked at
        inc_a = st_r.run_ctrl[RUN_A_BIT] & ev_a;
        inc_b = wide ? inc_a : (st_r.run_ctrl[RUN_B_BIT] & ev_b);

        // --------------------------------------------------------
        // counter steps
        // --------------------------------------------------------
        count16 = {st_r.count_b, st_r.count_a};
        period16 = {st_r.period_b, st_r.period_a};
        next16 = step16(count16, period16);
        set_a = 1'b0;
        set_b = 1'b0;

        if (wide) begin
            if (inc_a) begin
                st_nxt.count_a = next16[7:0];
                st_nxt.count_b = next16[15:8];
                set_a = (count16 == period16);
            end
        end else begin
            if (inc_a) begin
                st_nxt.count_a = step8(st_r.count_a, st_r.period_a);
                set_a = at_period8(st_r.count_a, st_r.period_a);
            end
            if (inc_b) begin
                st_nxt.count_b = step8(st_r.count_b, st_r.period_b);
                set_b = at_period8(st_r.count_b, st_r.period_b);
            end
        end

        // --------------------------------------------------------
        // software writes; a counter write replaces this cycle's step
        // --------------------------------------------------------
        // writing one half of the chained pair leaves the other half
        // stepping: stop the pair before reloading it
        if (wr) begin
            unique case (idx)
                IDX_COUNT_A: begin
                    st_nxt.count_a = wdat;
                end
                IDX_COUNT_B: begin
                    st_nxt.count_b = wdat;
                end
                IDX_PERIOD_A: begin
                    st_nxt.period_a = wdat;
                end
                IDX_PERIOD_B: begin
                    st_nxt.period_b = wdat;
                end
                IDX_PAIR_CTRL: begin
                    st_nxt.pair_ctrl = wdat & PAIR_CTRL_MASK;
                end
                IDX_RUN_CTRL: begin
                    st_nxt.run_ctrl = wdat & RUN_CTRL_MASK;
                end
                IDX_REQUEST: begin
                    st_nxt.request = wdat & REQUEST_MASK;
                end
                IDX_ENABLE: begin
                    st_nxt.enable = wdat & REQUEST_MASK;
                end
                IDX_INT_STATUS: begin
                    st_nxt.int_status = wdat & INT_STATUS_MASK;
                end
                IDX_CPU_STATUS: begin
                    st_nxt.cpu_status = wdat & CPU_STATUS_MASK;
                end
                default: begin
                end
            endcase
        end

        // a wrap in the same cycle as a clearing write still sets
        if (set_a) begin
            st_nxt.request[REQ_A_BIT] = 1'b1;
        end
        if (set_b) begin
            st_nxt.request[REQ_B_BIT] = 1'b1;
        end

        st_nxt.irq = irq_level(st_r);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r.count_a <= RST_BYTE;
            st_r.count_b <= RST_BYTE;
            st_r.period_a <= RST_BYTE;
            st_r.period_b <= RST_BYTE;
            st_r.pair_ctrl <= RST_BYTE;
            st_r.run_ctrl <= RST_BYTE;
            st_r.request <= RST_BYTE;
            st_r.enable <= RST_BYTE;
            st_r.int_status <= RST_BYTE;
            st_r.cpu_status <= RST_BYTE;
            st_r.phase <= RST_PHASE;
            st_r.pready <= 1'b0;
            st_r.pslverr <= 1'b0;
            st_r.prdata <= RST_WORD;
            st_r.irq <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_prdata = st_r.prdata;
    assign o_pready = st_r.pready;
    assign o_pslverr = st_r.pslverr;
    assign o_irq = st_r.irq;

endmodule
`default_nettype wire

// >>> design/dtp_pkg.sv
// Behaviour
// - width bit 0: two separate 8-bit counters
// - source bit: instruction tick or pin events
// - counter mode advances on pin falling edge
// - pin sampled twice per instruction cycle
// - 8-bit: count to period, then zero
// - counter A wrap latches its request flag
// - enable bit 0 hides counter request
// - request needs peripheral enable, no global disable
// - counter A runs only while run bit set
// - counter and period readable and writable
// - counter B mirrors A with own bits
// - width bit 1: chain into 16 bits
// - 16-bit: count to paired period, then zero
// - 16-bit wrap sets only flag A
// - 16-bit: source A governs, source B ignored
// - pin edge increments within 2 to 3 clocks
package dtp_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_COUNT_A = 6'h10;
    localparam logic [5:0] IDX_COUNT_B = 6'h11;
    localparam logic [5:0] IDX_PERIOD_A = 6'h14;
    localparam logic [5:0] IDX_PERIOD_B = 6'h15;
    localparam logic [5:0] IDX_PAIR_CTRL = 6'h16;
    localparam logic [5:0] IDX_RUN_CTRL = 6'h17;
    localparam logic [5:0] IDX_REQUEST = 6'h18;
    localparam logic [5:0] IDX_ENABLE = 6'h19;
    localparam logic [5:0] IDX_INT_STATUS = 6'h1A;
    localparam logic [5:0] IDX_CPU_STATUS = 6'h1B;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned SRC_A_BIT = 0;
    localparam int unsigned SRC_B_BIT = 1;
    localparam int unsigned WIDE_BIT = 3;
    localparam int unsigned RUN_A_BIT = 0;
    localparam int unsigned RUN_B_BIT = 1;
    localparam int unsigned REQ_A_BIT = 4;
    localparam int unsigned REQ_B_BIT = 5;
    localparam int unsigned PERIPH_EN_BIT = 3;
    localparam int unsigned GLOBAL_DIS_BIT = 4;

    // implemented bits; all others read as zero
    localparam logic [7:0] PAIR_CTRL_MASK = 8'h0B;
    localparam logic [7:0] RUN_CTRL_MASK = 8'h03;
    localparam logic [7:0] REQUEST_MASK = 8'h30;
    localparam logic [7:0] INT_STATUS_MASK = 8'h08;
    localparam logic [7:0] CPU_STATUS_MASK = 8'h10;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0] RST_PHASE = 2'h0;

    // ------------------------------------------------------------
    // instruction cycle: four clocks, pin sampled on two phases
    // ------------------------------------------------------------
    localparam logic [1:0] SAMPLE_PHASE_0 = 2'h0;
    localparam logic [1:0] SAMPLE_PHASE_1 = 2'h2;
    localparam logic [1:0] TICK_PHASE = 2'h3;

    typedef struct packed {
        logic [7:0] count_a;
        logic [7:0] count_b;
        logic [7:0] period_a;
        logic [7:0] period_b;
        logic [7:0] pair_ctrl;
        logic [7:0] run_ctrl;
        logic [7:0] request;
        logic [7:0] enable;
        logic [7:0] int_status;
        logic [7:0] cpu_status;
        logic [1:0] phase;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
    } dtp_state_t;

    typedef struct packed {
        logic sample;
        logic fall;
    } dtp_pin_state_t;

endpackage

// >>> design/dtp_pin_sampler.sv
`timescale 1ns/1ps
`default_nettype none
module dtp_pin_sampler
    import dtp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_sample_en,
    input wire logic i_pin,
    output logic o_fall
);

    dtp_pin_state_t st_r;
    dtp_pin_state_t st_nxt;

    // ------------------------------------------------------------
    // sampling and falling edge detection
    // ------------------------------------------------------------
    // the pin is only looked at on the sampling phases, so a pulse
    // shorter than half an instruction cycle may be missed
    always_comb begin
        st_nxt = st_r;
        st_nxt.fall = 1'b0;
        if (i_sample_en) begin
            st_nxt.sample = i_pin;
            st_nxt.fall = st_r.sample & ~i_pin;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_fall = st_r.fall;

endmodule
`default_nettype wire

// >>> verif/dtp_pin_source.sv
`timescale 1ns/1ps
`default_nettype none
module dtp_pin_source (
    input wire logic i_clk,
    output logic o_pin
);
    // idle high: only a driven low makes a falling edge
    initial o_pin = 1'h1;
    // ------------------------------------------------
    // pulse train
    // ------------------------------------------------
    // four clocks low, five high between pulses, above the two-clock sampler minimum
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge i_clk);
            o_pin <= 1'h0;
            repeat (4) @(posedge i_clk);
            o_pin <= 1'h1;
            repeat (4) @(posedge i_clk);
        end
    endtask
endmodule
`default_nettype wire

// >>> verif/dtp_timer_pair_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dtp_timer_pair_chk
    import dtp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic i_shared_count_pin,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_irq
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);
    // ------------------------------------------------
    // shadow of bits only software changes
    // ------------------------------------------------
    logic [5:0] ix;
    logic acc, wr, rd, um, pe_r, gd_r;
    logic [7:0] pa_r, pb_r, pc_r;
    logic [1:0] en_r;
    assign ix = i_paddr[7:2];
    assign acc = i_psel && i_penable && o_pready;
    assign wr = acc && i_pwrite;
    assign rd = acc && !i_pwrite;
    assign um = !(ix == IDX_COUNT_A || ix == IDX_COUNT_B ||
        (ix >= IDX_PERIOD_A && ix <= IDX_CPU_STATUS));
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pa_r <= 8'h00;
            pb_r <= 8'h00;
            pc_r <= 8'h00;
            en_r <= 2'h0;
            pe_r <= 1'h0;
            gd_r <= 1'h0;
        end else if (wr) begin
            if (ix == IDX_PERIOD_A) pa_r <= i_pwdata[7:0];
            if (ix == IDX_PERIOD_B) pb_r <= i_pwdata[7:0];
            if (ix == IDX_PAIR_CTRL) pc_r <= i_pwdata[7:0];
            if (ix == IDX_ENABLE) en_r <= i_pwdata[5:4];
            if (ix == IDX_INT_STATUS) pe_r <= i_pwdata[3];
            if (ix == IDX_CPU_STATUS) gd_r <= i_pwdata[4];
        end
    end
    property p_wait;
        (i_psel && !i_penable) ##1 (i_psel && i_penable)
            |-> !o_pready ##1 o_pready;
    endproperty
    a_wait: assert property (p_wait)
        else $error("pready not after one wait state");
    property p_pulse;
        o_pready |=> !o_pready;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("pready longer than one cycle");
    property p_err;
        o_pready |-> o_pslverr == um;
    endproperty
    a_err: assert property (p_err)
        else $error("pslverr wrong for address");
    property p_hi;
        o_pready |-> o_prdata[31:8] == 24'h000000;
    endproperty
    a_hi: assert property (p_hi)
        else $error("upper read data not zero");
    property p_rd_pa;
        rd && ix == IDX_PERIOD_A |-> o_prdata[7:0] == pa_r;
    endproperty
    a_rd_pa: assert property (p_rd_pa)
        else $error("period a read differs");
    property p_rd_pb;
        rd && ix == IDX_PERIOD_B |-> o_prdata[7:0] == pb_r;
    endproperty
    a_rd_pb: assert property (p_rd_pb)
        else $error("period b read differs");
    property p_ctrl;
        rd && ix == IDX_PAIR_CTRL |->
            o_prdata[7:0] == (pc_r & PAIR_CTRL_MASK);
    endproperty
    a_ctrl: assert property (p_ctrl)
        else $error("pair control read differs");
    property p_gate;
        o_irq |-> $past(pe_r) && !$past(gd_r);
    endproperty
    a_gate: assert property (p_gate)
        else $error("irq while gated off");
    property p_en;
        o_irq |-> $past(en_r) != 2'h0;
    endproperty
    a_en: assert property (p_en)
        else $error("irq with no enable bit");
endmodule
bind dtp_timer_pair dtp_timer_pair_chk chk_u (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .i_shared_count_pin(i_shared_count_pin),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_irq(o_irq)
);
`default_nettype wire

// >>> verif/tb_dtp_timer_pair.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dtp_timer_pair
    import dtp_pkg::*;
;
    logic i_clk, i_resetn, i_psel, i_penable, i_pwrite;
    logic [7:0] i_paddr, q;
    logic [31:0] i_pwdata, o_prdata;
    logic o_pready, o_pslverr, o_irq, pin, last_err;
    int error_cnt = 0;
    int tests_run = 0;
    logic [5:0] regs [10] = '{IDX_COUNT_A, IDX_COUNT_B, IDX_PERIOD_A,
        IDX_PERIOD_B, IDX_PAIR_CTRL, IDX_RUN_CTRL, IDX_REQUEST,
        IDX_ENABLE, IDX_INT_STATUS, IDX_CPU_STATUS};
    dtp_timer_pair dut_u (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .i_shared_count_pin(pin),
        .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .o_irq(o_irq)
    );
    dtp_pin_source pin_u (.i_clk(i_clk), .o_pin(pin));
    initial begin
        i_clk = 1'h0;
        forever #20 i_clk = ~i_clk;
    end
    // ------------------------------------------------
    // bus tasks
    // ------------------------------------------------
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic xfer(logic w, logic [5:0] ix, logic [7:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        i_psel <= 1'h1;
        i_penable <= 1'h0;
        i_pwrite <= w;
        i_paddr <= {ix, 2'h0};
        i_pwdata <= {24'h000000, d};
        @(posedge i_clk);
        i_penable <= 1'h1;
        // no cycle limit here: only the watchdog ends a dead wait
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'h1);
        q = o_prdata[7:0];
        last_err = o_pslverr;
        chk("wait", 8'h02, 8'(n));
        i_psel <= 1'h0;
        i_penable <= 1'h0;
    endtask
    task automatic wr(logic [5:0] ix, logic [7:0] d);
        xfer(1'h1, ix, d);
    endtask
    task automatic rc(string nm, logic [5:0] ix, logic [7:0] e);
        xfer(1'h0, ix, 8'h00);
        chk(nm, e, q);
    endtask
    task automatic irq_is(logic e);
        repeat (2) @(posedge i_clk);
        chk("irq", {7'h00, e}, {7'h00, o_irq});
    endtask
    task automatic stop_test;
        if (error_cnt == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_clk);
        error_cnt++;
        stop_test;
    end
    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    initial begin
        i_resetn = 1'h0;
        i_psel = 1'h0;
        i_penable = 1'h0;
        i_pwrite = 1'h0;
        i_paddr = 8'h00;
        i_pwdata = 32'h00000000;
        repeat (5) @(posedge i_clk);
        i_resetn <= 1'h1;
        repeat (3) @(posedge i_clk);
        foreach (regs[i]) rc("reset", regs[i], 8'h00);
        wr(IDX_PAIR_CTRL, 8'hFF);
        rc("pair_ctrl", IDX_PAIR_CTRL, 8'h0B);
        wr(IDX_RUN_CTRL, 8'hFF);
        rc("run_ctrl", IDX_RUN_CTRL, 8'h03);
        rc("unmapped", 6'h00, 8'h00);
        chk("slverr", 8'h01, {7'h00, last_err});
        // both counters on the pin, counter a halted
        wr(IDX_PAIR_CTRL, 8'h03);
        wr(IDX_PERIOD_A, 8'h02);
        wr(IDX_PERIOD_B, 8'h04);
        wr(IDX_RUN_CTRL, 8'h02);
        pin_u.pulse(3);
        rc("count_a halt", IDX_COUNT_A, 8'h00);
        rc("count_b", IDX_COUNT_B, 8'h03);
        wr(IDX_COUNT_B, 8'h00);
        wr(IDX_RUN_CTRL, 8'h03);
        pin_u.pulse(3);
        rc("count_a wrap", IDX_COUNT_A, 8'h00);
        rc("count_b", IDX_COUNT_B, 8'h03);
        rc("flag a", IDX_REQUEST, 8'h10);
        pin_u.pulse(2);
        rc("count_a", IDX_COUNT_A, 8'h02);
        rc("count_b wrap", IDX_COUNT_B, 8'h00);
        rc("flags", IDX_REQUEST, 8'h30);
        wr(IDX_REQUEST, 8'h00);
        rc("flags clr", IDX_REQUEST, 8'h00);
        // timer mode on the instruction tick, counter b left halted
        wr(IDX_RUN_CTRL, 8'h00);
        wr(IDX_PAIR_CTRL, 8'h00);
        wr(IDX_COUNT_A, 8'h00);
        wr(IDX_RUN_CTRL, 8'h01);
        repeat (30) @(posedge i_clk);
        wr(IDX_RUN_CTRL, 8'h00);
        rc("timer flag", IDX_REQUEST, 8'h10);
        rc("count_b halt", IDX_COUNT_B, 8'h00);
        wr(IDX_ENABLE, 8'h10);
        wr(IDX_INT_STATUS, 8'h08);
        irq_is(1'h1);
        wr(IDX_CPU_STATUS, 8'h10);
        irq_is(1'h0);
        wr(IDX_CPU_STATUS, 8'h00);
        wr(IDX_ENABLE, 8'h20);
        irq_is(1'h0);
        wr(IDX_ENABLE, 8'h10);
        wr(IDX_REQUEST, 8'h00);
        // chained pair, source b left on timer and ignored
        wr(IDX_PAIR_CTRL, 8'h09);
        wr(IDX_PERIOD_B, 8'h01);
        rc("period_b", IDX_PERIOD_B, 8'h01);
        rc("period_a", IDX_PERIOD_A, 8'h02);
        wr(IDX_COUNT_A, 8'hFE);
        wr(IDX_COUNT_B, 8'h00);
        wr(IDX_RUN_CTRL, 8'h03);
        pin_u.pulse(3);
        rc("wide lo", IDX_COUNT_A, 8'h01);
        rc("wide hi", IDX_COUNT_B, 8'h01);
        pin_u.pulse(2);
        rc("wide lo wrap", IDX_COUNT_A, 8'h00);
        rc("wide hi wrap", IDX_COUNT_B, 8'h00);
        rc("wide flag", IDX_REQUEST, 8'h10);
        irq_is(1'h1);
        stop_test;
    end
endmodule
`default_nettype wire
